//--- design/adt_params.svh
`ifndef ADT_PARAMS_SVH
`define ADT_PARAMS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ADT_OFS_CTRL 8'h00
`define ADT_OFS_CR0 8'h04
`define ADT_OFS_CR1 8'h08
`define ADT_OFS_DIRB 8'h0C
`define ADT_OFS_STAT 8'h10
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADT_CTRL_FULL 0
`define ADT_CTRL_EXT 1
`define ADT_CTRL_TRANS 2
`define ADT_CTRL_PROB 3
`define ADT_CR0_PG_HI 23
`define ADT_CR0_PG_LO 22
`define ADT_CR0_SG_HI 20
`define ADT_CR0_SG_LO 19
`define ADT_STE_INV 0
`define ADT_PTE_INV_2K 2
`define ADT_PTE_INV_4K 3
// ----------------------------------------
// Size codes and reset values
// ----------------------------------------
`define ADT_SEG_1M 2'h2
`define ADT_SEG_64K 2'h0
`define ADT_PG_2K 2'h1
`define ADT_PG_4K 2'h2
`define ADT_RST_CTRL 32'h0000_0000
`define ADT_RST_CR0 32'h0080_0000
`define ADT_RST_CR1 32'h0000_0000
`define ADT_RST_DIRB 32'h0000_0000
`endif

//--- design/adt_pkg.sv
package adt_pkg;
   // Request kinds from the execution logic
   typedef enum logic [2:0] {
      ADT_K_FETCH = 3'h0,
      ADT_K_DATA = 3'h1,
      ADT_K_LRA = 3'h2,
      ADT_K_PURGE_TRANSLATION_BUFFER = 3'h3,
      ADT_K_RRB = 3'h4,
      ADT_K_CHAN = 3'h5
   } adt_kind_e;
   // Result codes
   typedef enum logic [2:0] {
      ADT_X_NONE = 3'h0,
      ADT_X_OPER = 3'h1,
      ADT_X_PRIV = 3'h2,
      ADT_X_SPEC = 3'h3,
      ADT_X_SEG = 3'h4,
      ADT_X_PAGE = 3'h5
   } adt_excp_e;
   // Walk states, one-hot
   typedef enum logic [6:0] {
      ADT_S_IDLE = 7'b000_0001,
      ADT_S_SEGD = 7'b000_0010,
      ADT_S_SEGR = 7'b000_0100,
      ADT_S_PAGED = 7'b000_1000,
      ADT_S_PAGER = 7'b001_0000,
      ADT_S_FRMD = 7'b010_0000,
      ADT_S_RESP = 7'b100_0000
   } adt_state_e;
   typedef struct packed {
      adt_kind_e kind;
      logic [23:0] vaddr;
   } adt_req_s;
   typedef struct packed {
      adt_excp_e excp;
      logic [1:0] cc;
      logic [23:0] real_addr;
      logic [23:0] proc_addr;
   } adt_rsp_s;
endpackage

//--- design/adt_translate.sv
`timescale 1ns/1ns
`include "adt_params.svh"
// Function
// - Translate only in full, extended mode, bit set
// - Translate fetch and data addresses when active
// - Inactive: program address used as real
// - Channel addresses never translated
// - Load real, purge only in full mode
// - Three instructions privileged, mode-independent
// - Segment size from bits 11,12
// - Page size from bits 8,9
// - Codes select 1M/64K segments, 2K/4K pages
// - Page index range follows size pair
// - Full 16 MB virtual space always
// - Split into segment, page, byte fields
// - Real storage contiguous from zero
// - Real address mapped through storage directory in full mode, except load real
// - Tables fetched with directory references
// - No common segments
// - Segment table origin, length from CR1
// - Invalid segment entry: segment exception
// - Invalid page entry: page exception
// - Load real reports through condition code
module adt_translate (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   // Avalon-MM register slave
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Requests from instruction execution
   input wire logic req_valid_in,
   input wire adt_pkg::adt_req_s req_in,
   output logic req_ready_out,
   output logic rsp_valid_out,
   output adt_pkg::adt_rsp_s rsp_out,
   // Processor storage word reads
   output logic mem_rd_out,
   output logic [23:0] mem_addr_out,
   input wire logic [31:0] mem_rdata_in,
   input wire logic mem_ack_in
);
   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_s1_r, rst_n_r;
   // Two-stage release so no flop leaves reset on a skewed edge
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   // ----------------------------------------
   // Register slave
   // ----------------------------------------
   logic [31:0] ctrl_r, cr0_r, cr1_r, dirb_r, rdata_nxt;
   logic wait_r, busy;
   adt_pkg::adt_excp_e excp_r;
   logic [1:0] cc_r;
   wire acc = avs_read_in | avs_write_in;
   wire wr_go = avs_write_in & ~wait_r;
   wire sel_ctrl = avs_address_in == `ADT_OFS_CTRL;
   wire sel_cr0 = avs_address_in == `ADT_OFS_CR0;
   wire sel_cr1 = avs_address_in == `ADT_OFS_CR1;
   wire sel_dirb = avs_address_in == `ADT_OFS_DIRB;
   wire sel_stat = avs_address_in == `ADT_OFS_STAT;
   // Read mux; unmapped words read as zero
   assign rdata_nxt = sel_ctrl ? {28'h000_0000, ctrl_r[3:0]} :
                      sel_cr0 ? cr0_r :
                      sel_cr1 ? cr1_r :
                      sel_dirb ? dirb_r :
                      sel_stat ? {26'h000_0000, cc_r, excp_r, busy} : 32'h0000_0000;

   // One wait cycle per access, then a single answer edge
   always_ff @(posedge core_clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         wait_r <= 1'b1;
         avs_readdata_out <= 32'h0000_0000;
         ctrl_r <= `ADT_RST_CTRL;
         cr0_r <= `ADT_RST_CR0;
         cr1_r <= `ADT_RST_CR1;
         dirb_r <= `ADT_RST_DIRB;
      end else begin
         wait_r <= ~(acc & wait_r);
         if (avs_read_in & wait_r) begin
            avs_readdata_out <= rdata_nxt;
         end
         if (wr_go & sel_ctrl) begin
            ctrl_r <= avs_writedata_in;
         end
         if (wr_go & sel_cr0) begin
            cr0_r <= avs_writedata_in;
         end
         if (wr_go & sel_cr1) begin
            cr1_r <= avs_writedata_in;
         end
         if (wr_go & sel_dirb) begin
            dirb_r <= avs_writedata_in;
         end
      end
   end
   assign avs_waitrequest_out = wait_r;

   // ----------------------------------------
   // Mode and size decode
   // ----------------------------------------
   wire full_mode = ctrl_r[`ADT_CTRL_FULL];
   wire prob_state = ctrl_r[`ADT_CTRL_PROB];
   // Translation needs all three conditions
   wire xlat_on = full_mode & ctrl_r[`ADT_CTRL_EXT] & ctrl_r[`ADT_CTRL_TRANS];
   wire [1:0] seg_code = cr0_r[`ADT_CR0_SG_HI:`ADT_CR0_SG_LO];
   wire [1:0] pg_code = cr0_r[`ADT_CR0_PG_HI:`ADT_CR0_PG_LO];
   wire seg_1m = seg_code == `ADT_SEG_1M;
   wire pg_2k = pg_code == `ADT_PG_2K;
   wire cfg_bad = !(seg_1m || seg_code == `ADT_SEG_64K) || !(pg_2k || pg_code == `ADT_PG_4K);

   // ----------------------------------------
   // Request decode
   // ----------------------------------------
   adt_pkg::adt_state_e state_r;
   adt_pkg::adt_req_s cur_r;
   logic [23:0] real_r;
   wire taken = req_valid_in & req_ready_out;
   wire [23:0] va = req_in.vaddr;
   wire k_lra = req_in.kind == adt_pkg::ADT_K_LRA;
   wire k_purge_translation_buffer = req_in.kind == adt_pkg::ADT_K_PURGE_TRANSLATION_BUFFER;
   wire k_rrb = req_in.kind == adt_pkg::ADT_K_RRB;
   wire k_chan = req_in.kind == adt_pkg::ADT_K_CHAN;
   wire k_prog = req_in.kind == adt_pkg::ADT_K_FETCH || req_in.kind == adt_pkg::ADT_K_DATA;
   wire k_bad = !(k_lra | k_purge_translation_buffer | k_rrb | k_chan | k_prog);
   wire k_sys = k_lra | k_purge_translation_buffer | k_rrb;
   wire need_oper = k_bad | ((k_lra | k_purge_translation_buffer) & ~full_mode);
   wire need_priv = k_sys & prob_state;
   // Load real translates whatever the translation bit says
   wire walk = (k_prog & xlat_on) | k_lra;
   // Segment index; 1M segments give 16, 64K give 256
   wire [7:0] seg_ix = seg_1m ? {4'h0, va[23:20]} : va[23:16];
   // Page index per size pair: 512/256/32/16 entries
   wire [8:0] pg_ix = seg_1m ? (pg_2k ? va[19:11] : {1'b0, va[19:12]}) :
                      (pg_2k ? {4'h0, va[15:11]} : {5'h00, va[15:12]});
   // Length counts 16-entry blocks, one more than coded
   wire seg_long = seg_ix[7:4] > cr1_r[27:24];
   // Single table from CR1; no shared segment path
   wire [23:0] ste_addr = {cr1_r[23:6], 6'h00} + {14'h0000, seg_ix, 2'h0};

   // ----------------------------------------
   // Walk helpers
   // ----------------------------------------
   // Directory word for a real address; real space starts at zero
   function automatic logic [23:0] dir_word(input logic [31:0] base, input logic [23:0] ra);
      dir_word = base[23:0] + {9'h000, ra[23:11], 2'h0};
   endfunction
   logic [8:0] pg_ix_r;
   logic seg1m_r, pg2k_r;
   wire [23:0] proc_addr = {mem_rdata_in[31:19], real_r[10:0]};
   wire [23:0] pte_addr = {mem_rdata_in[23:3], 3'h0} + {14'h0000, pg_ix_r, 1'b0};
   wire [15:0] pte = real_r[1] ? mem_rdata_in[15:0] : mem_rdata_in[31:16];
   wire pte_inv = pg2k_r ? pte[`ADT_PTE_INV_2K] : pte[`ADT_PTE_INV_4K];
   wire [23:0] pg_real = pg2k_r ? {pte[15:3], cur_r.vaddr[10:0]} : {pte[15:4], cur_r.vaddr[11:0]};
   wire is_lra = cur_r.kind == adt_pkg::ADT_K_LRA;
   wire st_idle = state_r == adt_pkg::ADT_S_IDLE;
   assign busy = ~st_idle;

   // ----------------------------------------
   // Translation walk
   // ----------------------------------------
   // Each table step reads the directory first, then the table word
   always_ff @(posedge core_clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r <= adt_pkg::ADT_S_IDLE;
         cur_r <= '0;
         real_r <= 24'h00_0000;
         pg_ix_r <= 9'h000;
         seg1m_r <= 1'b0;
         pg2k_r <= 1'b0;
         excp_r <= adt_pkg::ADT_X_NONE;
         cc_r <= 2'h0;
         req_ready_out <= 1'b0;
         rsp_valid_out <= 1'b0;
         rsp_out <= '0;
         mem_rd_out <= 1'b0;
         mem_addr_out <= 24'h00_0000;
      end else begin
         rsp_valid_out <= 1'b0;
         unique case (state_r)
            adt_pkg::ADT_S_IDLE: begin
               req_ready_out <= 1'b1;
               if (taken) begin
                  req_ready_out <= 1'b0;
                  cur_r <= req_in;
                  pg_ix_r <= pg_ix;
                  seg1m_r <= seg_1m;
                  pg2k_r <= pg_2k;
                  real_r <= va;
                  excp_r <= adt_pkg::ADT_X_NONE;
                  cc_r <= 2'h0;
                  state_r <= adt_pkg::ADT_S_RESP;
                  if (need_oper) begin
                     excp_r <= adt_pkg::ADT_X_OPER;
                  end else if (need_priv) begin
                     excp_r <= adt_pkg::ADT_X_PRIV;
                  end else if (walk & cfg_bad) begin
                     excp_r <= adt_pkg::ADT_X_SPEC;
                  end else if (walk & seg_long) begin
                     if (k_lra) begin
                        cc_r <= 2'h3;
                     end else begin
                        excp_r <= adt_pkg::ADT_X_SEG;
                     end
                  end else if (walk) begin
                     real_r <= ste_addr;
                     mem_addr_out <= dir_word(dirb_r, ste_addr);
                     mem_rd_out <= 1'b1;
                     state_r <= adt_pkg::ADT_S_SEGD;
                  end else if ((k_prog | k_chan) & full_mode) begin
                     mem_addr_out <= dir_word(dirb_r, va);
                     mem_rd_out <= 1'b1;
                     state_r <= adt_pkg::ADT_S_FRMD;
                  end
               end
            end
            adt_pkg::ADT_S_SEGD, adt_pkg::ADT_S_PAGED: begin
               if (mem_ack_in) begin
                  mem_addr_out <= {proc_addr[23:2], 2'h0};
                  state_r <= state_r == adt_pkg::ADT_S_SEGD ? adt_pkg::ADT_S_SEGR : adt_pkg::ADT_S_PAGER;
               end
            end
            adt_pkg::ADT_S_SEGR: begin
               if (mem_ack_in) begin
                  if (mem_rdata_in[`ADT_STE_INV]) begin
                     mem_rd_out <= 1'b0;
                     state_r <= adt_pkg::ADT_S_RESP;
                     if (is_lra) begin
                        cc_r <= 2'h1;
                     end else begin
                        excp_r <= adt_pkg::ADT_X_SEG;
                     end
                  end else begin
                     real_r <= pte_addr;
                     mem_addr_out <= dir_word(dirb_r, pte_addr);
                     state_r <= adt_pkg::ADT_S_PAGED;
                  end
               end
            end
            adt_pkg::ADT_S_PAGER: begin
               if (mem_ack_in) begin
                  if (pte_inv) begin
                     mem_rd_out <= 1'b0;
                     state_r <= adt_pkg::ADT_S_RESP;
                     if (is_lra) begin
                        cc_r <= 2'h2;
                     end else begin
                        excp_r <= adt_pkg::ADT_X_PAGE;
                     end
                  end else begin
                     real_r <= pg_real;
                     if (is_lra) begin
                        mem_rd_out <= 1'b0;
                        state_r <= adt_pkg::ADT_S_RESP;
                     end else begin
                        mem_addr_out <= dir_word(dirb_r, pg_real);
                        state_r <= adt_pkg::ADT_S_FRMD;
                     end
                  end
               end
            end
            adt_pkg::ADT_S_FRMD: begin
               if (mem_ack_in) begin
                  mem_rd_out <= 1'b0;
                  rsp_out.proc_addr <= proc_addr;
                  state_r <= adt_pkg::ADT_S_RESP;
               end
            end
            adt_pkg::ADT_S_RESP: begin
               // Outside full mode the program address goes straight out
               if (!full_mode || is_lra) begin
                  rsp_out.proc_addr <= real_r;
               end
               rsp_out.real_addr <= real_r;
               rsp_out.excp <= excp_r;
               rsp_out.cc <= cc_r;
               rsp_valid_out <= 1'b1;
               state_r <= adt_pkg::ADT_S_IDLE;
            end
            default: begin
               state_r <= adt_pkg::ADT_S_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_r);
   a_xlat_walk_start: assert property (taken && k_prog && xlat_on && !cfg_bad && !seg_long && !prob_state
      |=> state_r == adt_pkg::ADT_S_SEGD) else $error("walk not started");
   a_inactive_direct: assert property (taken && k_prog && !xlat_on && full_mode
      |=> state_r == adt_pkg::ADT_S_FRMD && mem_addr_out == dir_word(dirb_r, $past(va))) else $error("bad direct");
   a_chan_no_walk: assert property (taken && k_chan |=> state_r != adt_pkg::ADT_S_SEGD) else $error("chan walked");
   a_oper_basic: assert property (taken && k_lra && !full_mode
      |=> ##1 rsp_valid_out && rsp_out.excp == adt_pkg::ADT_X_OPER) else $error("no operation exc");
   a_priv_problem: assert property (taken && !need_oper && k_sys && prob_state
      |=> ##1 rsp_out.excp == adt_pkg::ADT_X_PRIV) else $error("no privileged exc");
   a_spec_badcfg: assert property (taken && k_prog && xlat_on && cfg_bad && !prob_state
      |=> ##1 rsp_out.excp == adt_pkg::ADT_X_SPEC) else $error("no spec exc");
   a_seg_invalid: assert property (state_r == adt_pkg::ADT_S_SEGR && mem_ack_in && mem_rdata_in[0] && !is_lra
      |=> ##1 rsp_valid_out && rsp_out.excp == adt_pkg::ADT_X_SEG) else $error("no segment exc");
   a_page_invalid: assert property (state_r == adt_pkg::ADT_S_PAGER && mem_ack_in && pte_inv && !is_lra
      |=> ##1 rsp_out.excp == adt_pkg::ADT_X_PAGE) else $error("no page exc");
   a_lra_no_intr: assert property (rsp_valid_out && $past(is_lra, 2)
      |-> rsp_out.excp != adt_pkg::ADT_X_SEG && rsp_out.excp != adt_pkg::ADT_X_PAGE) else $error("lra interrupted");
   a_bus_wait_one: assert property (acc && avs_waitrequest_out |=> !avs_waitrequest_out) else $error("wait stuck");
endmodule

//--- sim/adt_stor_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Processor storage model
// ----------------------------------------
module adt_stor_model (
   // Clock
   input wire logic core_clk_in,
   // Storage read port
   input wire logic mem_rd_in,
   input wire logic [23:0] mem_addr_in,
   output logic [31:0] mem_rdata_out,
   output logic mem_ack_out
);
   int reads = 0;
   int wait_r = 0;
   // Fixed contents hashed from the word address, so the bench can predict a walk
   function automatic logic [31:0] word_at(input logic [23:0] a);
      logic [31:0] x;
      x = {8'h00, a[23:2], 2'b00} * 32'h9e37_79b1;
      return x ^ (x >> 13);
   endfunction
   initial begin
      mem_ack_out = 1'b0;
      mem_rdata_out = 32'h0000_0000;
   end
   // Ack after 0 to 3 idle cycles; data bus is junk outside the ack cycle
   always @(posedge core_clk_in) begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= $urandom;
      if (mem_rd_in && !mem_ack_out) begin
         if (wait_r == 0) begin
            mem_ack_out <= 1'b1;
            mem_rdata_out <= word_at(mem_addr_in);
            reads <= reads + 1;
            wait_r <= $urandom_range(3);
         end else begin
            wait_r <= wait_r - 1;
         end
      end
   end
endmodule

//--- sim/tb_dynamic_address_translation.sv
`timescale 1ns/1ns
`include "adt_params.svh"
module tb_dynamic_address_translation;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic rqv = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   adt_pkg::adt_req_s rq = '0;
   logic [31:0] rdata, mdata, q;
   logic wreq, rdy, rspv, mrd, mack;
   logic [23:0] maddr;
   adt_pkg::adt_rsp_s rsp;
   logic [31:0] ctrl = 32'h0000_0000;
   logic [31:0] cr0 = `ADT_RST_CR0;
   logic [31:0] cr1 = 32'h0000_0000;
   logic [31:0] dirb = 32'h0000_0000;
   logic [7:0] oa [6] = '{`ADT_OFS_CTRL, `ADT_OFS_CR0, `ADT_OFS_CR1, `ADT_OFS_DIRB, `ADT_OFS_STAT, 8'h14};
   logic [31:0] ov [6] = '{`ADT_RST_CTRL, `ADT_RST_CR0, `ADT_RST_CR1, `ADT_RST_DIRB, 32'h0000_0000, 32'h0000_0000};
   logic [2:0] ks [4] = '{3'h0, 3'h1, 3'h2, 3'h5};
   int fails = 0;
   int compares = 0;

   adt_translate i_adt_translate (.core_clk_in(clk), .arst_n_in(arst_n), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
      .avs_waitrequest_out(wreq), .req_valid_in(rqv), .req_in(rq), .req_ready_out(rdy),
      .rsp_valid_out(rspv), .rsp_out(rsp), .mem_rd_out(mrd), .mem_addr_out(maddr),
      .mem_rdata_in(mdata), .mem_ack_in(mack));
   adt_stor_model i_adt_stor_model (.core_clk_in(clk), .mem_rd_in(mrd), .mem_addr_in(maddr),
      .mem_rdata_out(mdata), .mem_ack_out(mack));

   // Clock, 8 ns period
   initial begin
      forever #4 clk = ~clk;
   end
   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task automatic give_verdict;
      $display("checks %0d failures %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t register got %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk_rsp(input adt_pkg::adt_rsp_s e, input int nrd, input bit ac, input int got);
      compares++;
      if (rsp.excp !== e.excp || rsp.cc !== e.cc || got != nrd
          || (ac && (rsp.real_addr !== e.real_addr || rsp.proc_addr !== e.proc_addr))) begin
         fails++;
         $display("CHECK FAILED %0t req %h got %h/%0d want %h/%0d", $time, rq, rsp, got, e, nrd);
      end
   endtask
   // Master holds the request until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      if (wreq !== 1'b0) begin
         fails++;
         $display("CHECK FAILED %0t bus hang", $time);
      end
      r = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
      case (a)
         `ADT_OFS_CTRL: ctrl = d;
         `ADT_OFS_CR0: cr0 = d;
         `ADT_OFS_CR1: cr1 = d;
         `ADT_OFS_DIRB: dirb = d;
         default: ;
      endcase
   endtask
   // ----------------------------------------
   // Reference walk
   // ----------------------------------------
   function automatic logic [23:0] px(input logic [23:0] r);
      logic [31:0] d;
      d = i_adt_stor_model.word_at(dirb[23:0] + {r[23:11], 2'b00});
      return {d[31:19], r[10:0]};
   endfunction
   function automatic void exp_of(input logic [2:0] k, input logic [23:0] v, output adt_pkg::adt_rsp_s e,
                                  output int nrd, output bit ac);
      logic [1:0] sc, pc;
      logic [7:0] si;
      logic [8:0] pi;
      logic [23:0] a;
      logic [31:0] w;
      logic [15:0] h;
      e = '0;
      nrd = 0;
      ac = 1'b0;
      sc = cr0[20:19];
      pc = cr0[23:22];
      if (k > 3'h5 || (k inside {3'h2, 3'h3} && !ctrl[0])) e.excp = adt_pkg::ADT_X_OPER;
      else if (k inside {3'h2, 3'h3, 3'h4} && ctrl[3]) e.excp = adt_pkg::ADT_X_PRIV;
      if (e.excp != adt_pkg::ADT_X_NONE || k inside {3'h3, 3'h4}) return;
      ac = 1'b1;
      a = v;
      if (!ctrl[0]) begin
         e.real_addr = v;
         e.proc_addr = v;
         return;
      end
      if (k == 3'h2 || (k < 3'h2 && ctrl[2] && ctrl[1])) begin
         ac = 1'b0;
         if (!(sc inside {2'h0, 2'h2}) || !(pc inside {2'h1, 2'h2})) begin
            e.excp = adt_pkg::ADT_X_SPEC;
            return;
         end
         si = sc[1] ? {4'h0, v[23:20]} : v[23:16];
         pi = sc[1] ? (pc[1] ? {1'b0, v[19:12]} : v[19:11]) : (pc[1] ? {5'h00, v[15:12]} : {4'h0, v[15:11]});
         if (si[7:4] > cr1[27:24]) begin
            if (k == 3'h2) e.cc = 2'h3;
            else e.excp = adt_pkg::ADT_X_SEG;
            return;
         end
         w = i_adt_stor_model.word_at(px({cr1[23:6], 6'h00} + {14'h0000, si, 2'b00}));
         nrd = 2;
         if (w[0]) begin
            if (k == 3'h2) e.cc = 2'h1;
            else e.excp = adt_pkg::ADT_X_SEG;
            return;
         end
         a = {w[23:3], 3'h0} + {14'h0000, pi, 1'b0};
         w = i_adt_stor_model.word_at(px(a));
         nrd = 4;
         h = a[1] ? w[15:0] : w[31:16];
         if (pc[1] ? h[3] : h[2]) begin
            if (k == 3'h2) e.cc = 2'h2;
            else e.excp = adt_pkg::ADT_X_PAGE;
            return;
         end
         ac = 1'b1;
         a = pc[1] ? {h[15:4], v[11:0]} : {h[15:3], v[10:0]};
         if (k == 3'h2) begin
            e.real_addr = a;
            e.proc_addr = a;
            return;
         end
      end
      e.real_addr = a;
      e.proc_addr = px(a);
      nrd = nrd + 1;
   endfunction
   // One translation request, then compare the answer and the storage read count
   task automatic xlate(input logic [2:0] k, input logic [23:0] v);
      adt_pkg::adt_rsp_s e;
      int n, r0, nrd;
      bit ac;
      exp_of(k, v, e, nrd, ac);
      n = 0;
      @(negedge clk);
      while (rdy !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      if (n == 100) begin
         fails++;
         $display("CHECK FAILED %0t never ready", $time);
      end
      @(posedge clk);
      r0 = i_adt_stor_model.reads;
      rqv <= 1'b1;
      rq <= {k, v};
      @(posedge clk);
      rqv <= 1'b0;
      n = 0;
      while (rspv !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (n == 200) begin
         fails++;
         $display("CHECK FAILED %0t no response", $time);
      end
      chk_rsp(e, nrd, ac, i_adt_stor_model.reads - r0);
   endtask
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'hcdeb));
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      repeat (5) @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, oa[i], 32'h0000_0000, q);
         chk_reg(q, ov[i]);
      end
      wreg(8'h14, 32'hffff_ffff);
      bus(1'b0, 8'h14, 32'h0000_0000, q);
      chk_reg(q, 32'h0000_0000);
      wreg(`ADT_OFS_CR0, 32'h0050_0000);
      bus(1'b0, `ADT_OFS_CR0, 32'h0000_0000, q);
      chk_reg(q, 32'h0050_0000);
      wreg(`ADT_OFS_DIRB, $urandom & 32'h00ff_fffc);
      wreg(`ADT_OFS_CR1, ($urandom & 32'h00ff_ffc0) | 32'h0f00_0000);
      bus(1'b0, `ADT_OFS_CR1, 32'h0000_0000, q);
      chk_reg(q, cr1);
      $display("test registers done");
      // Every mode bit combination against every request kind
      for (int c = 0; c < 16; c++) begin
         wreg(`ADT_OFS_CTRL, c);
         for (int k = 0; k < 8; k++) xlate(k[2:0], $urandom & 32'h007f_ffff);
      end
      $display("test modes done");
      // All size codes, valid and undefined, with translation on
      wreg(`ADT_OFS_CTRL, 32'h0000_0007);
      for (int s = 0; s < 16; s++) begin
         wreg(`ADT_OFS_CR0, {8'h00, s[3:2], 1'b0, s[1:0], 19'h0_0000});
         for (int i = 0; i < 6; i++) xlate(ks[$urandom_range(3)], $urandom & 32'h007f_ffff);
      end
      $display("test sizes done");
      // Segment table length boundary
      wreg(`ADT_OFS_CR0, `ADT_RST_CR0);
      wreg(`ADT_OFS_CR1, cr1 & 32'h00ff_ffff);
      xlate(3'h0, 24'h10_0000);
      xlate(3'h2, 24'h10_1234);
      // Status keeps the length-exceeded condition code of the last request
      bus(1'b0, `ADT_OFS_STAT, 32'h0000_0000, q);
      chk_reg(q, 32'h0000_0030);
      wreg(`ADT_OFS_CR1, cr1 | 32'h0100_0000);
      xlate(3'h1, 24'h05_0800);
      $display("test length done");
      give_verdict;
   end
   // Watchdog well past the expected run time
   initial begin
      #400_000;
      fails++;
      $display("CHECK FAILED %0t timeout", $time);
      give_verdict;
   end
endmodule
